// File: include/rx_accept_pkg.sv
// Constants for the receive accept control block: register offset, field
// positions, reset value and state codes. Assumes a 16-bit host register port.
// Notes on behaviour
// - While flush is set, queue memory is cleared and frame pointer reset.
// - UDP checksum check enabled: bad UDP frames are discarded.
// - TCP checksum check enabled: bad TCP frames are discarded.
// - IP header check enabled: bad IP header frames are discarded.
// - Station filter enable, set after reset, accepts unicast passing station filter.
// - Pause honour in full duplex holds transmit until pause timer expires.
// - Error accept stores CRC error frames; otherwise they are discarded.
// - Group filter enable accepts multicast passing the station filter.
// - Broadcast accept takes every broadcast frame.
// - All-group accept takes every multicast, broadcast included.
// - Own unicast accept takes unicast matching the 48-bit station address.
// - Promiscuous accept takes every frame regardless of destination.
// - Inverse filter inverts the destination address decision.
// - Setting run enable puts receive into running state.
// - Clearing run enable finishes current frame, then stops.
`default_nettype none

package rx_accept_pkg;
  localparam logic [7:0] RECEIVE_CONTROL_ONE_OFFSET = 8'h74;
  localparam logic [15:0] RECEIVE_CONTROL_ONE_RESET = 16'h0800;
  localparam int RX_QUEUE_FLUSH_BIT = 15;
  localparam int UDP_CHECKSUM_CHECK_EN_BIT = 14;
  localparam int TCP_CHECKSUM_CHECK_EN_BIT = 13;
  localparam int IP_HEADER_CHECKSUM_CHECK_EN_BIT = 12;
  localparam int STATION_ADDR_FILTER_EN_BIT = 11;
  localparam int PAUSE_HONOUR_EN_BIT = 10;
  localparam int CRC_ERROR_FRAME_ACCEPT_BIT = 9;
  localparam int GROUP_ADDR_FILTER_EN_BIT = 8;
  localparam int BROADCAST_ACCEPT_BIT = 7;
  localparam int ALL_GROUP_ACCEPT_BIT = 6;
  localparam int OWN_UNICAST_ACCEPT_BIT = 5;
  localparam int PROMISCUOUS_ACCEPT_BIT = 4;
  localparam int INVERSE_ADDR_FILTER_BIT = 1;
  localparam int RX_RUN_ENABLE_BIT = 0;
  localparam logic [47:0] BROADCAST_ADDR = 48'hFFFFFFFFFFFF;
  localparam int PAUSE_QUANTUM_CYCLES = 16'h0040;

  typedef enum logic [2:0] {
    RX_STOPPED = 3'h1,
    RX_RUNNING = 3'h2,
    RX_IN_FRAME = 3'h4
  } rx_state_t;
endpackage : rx_accept_pkg

`default_nettype wire

// File: rtl/rx_addr_match.sv
// Destination address classifier: combinational accept decision for one frame.
// Assumes the destination and station address are stable while sampled.
`default_nettype none

module rx_addr_match (
  // Frame destination and station identity
  input wire logic [47:0] dest_addr_i,
  input wire logic [47:0] station_addr_i,
  input wire logic filter_hit_i,
  // Control fields
  input wire logic [15:0] control_i,
  // Decision
  output logic accept_o
);
  logic is_group;
  logic is_bcast;
  logic hit;

  always_comb begin
    // Group bit is the first transmitted bit, bit 40 in this byte order
    is_group = dest_addr_i[40];
    is_bcast = (dest_addr_i == rx_accept_pkg::BROADCAST_ADDR);
    hit = 1'b0;
    if (control_i[rx_accept_pkg::PROMISCUOUS_ACCEPT_BIT]) begin
      hit = 1'b1;
    end
    if (control_i[rx_accept_pkg::BROADCAST_ACCEPT_BIT] && is_bcast) begin
      hit = 1'b1;
    end
    if (control_i[rx_accept_pkg::ALL_GROUP_ACCEPT_BIT] && is_group) begin
      hit = 1'b1;
    end
    if (control_i[rx_accept_pkg::OWN_UNICAST_ACCEPT_BIT] && !is_group
        && dest_addr_i == station_addr_i) begin
      hit = 1'b1;
    end
    if (control_i[rx_accept_pkg::STATION_ADDR_FILTER_EN_BIT] && !is_group && filter_hit_i) begin
      hit = 1'b1;
    end
    if (control_i[rx_accept_pkg::GROUP_ADDR_FILTER_EN_BIT] && is_group && filter_hit_i) begin
      hit = 1'b1;
    end
    accept_o = hit ^ control_i[rx_accept_pkg::INVERSE_ADDR_FILTER_BIT];
  end
endmodule : rx_addr_match

`default_nettype wire

// File: rtl/rx_frame_accept_control.sv
// Receive accept control: holds the receive control register, runs the
// receive state, decides accept or discard at frame end and drives pause hold.
// Assumes frame start and end pulses plus check results come from the MAC.
`default_nettype none

module rx_frame_accept_control (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Host register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [1:0] reg_be_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  // Station identity, external filter result and duplex mode
  input wire logic [47:0] station_addr_i,
  input wire logic filter_hit_i,
  input wire logic full_duplex_i,
  // Incoming frame from the MAC
  input wire logic frame_start_i,
  input wire logic frame_end_i,
  input wire logic [47:0] dest_addr_i,
  input wire logic crc_error_i,
  input wire logic is_ip_i,
  input wire logic ip_csum_bad_i,
  input wire logic is_tcp_i,
  input wire logic tcp_csum_bad_i,
  input wire logic is_udp_i,
  input wire logic udp_csum_bad_i,
  input wire logic is_pause_i,
  input wire logic [15:0] pause_quanta_i,
  // Decisions
  output logic frame_store_o,
  output logic frame_drop_o,
  output logic queue_flush_o,
  output logic rx_running_o,
  output logic tx_pause_hold_o
);
  typedef struct packed {
    logic [15:0] ctrl;
    rx_accept_pkg::rx_state_t state;
    logic [47:0] dest;
    logic store;
    logic drop;
    logic flush;
    logic [15:0] rdata;
    logic [15:0] quanta;
    logic [6:0] sub;
    logic running;
    logic hold;
  } state_t;

  state_t st_reg;
  state_t st_next;
  logic addr_ok;
  logic [15:0] c;
  logic pause_load;

  assign c = st_reg.ctrl;

  rx_addr_match u_match (
    .dest_addr_i(st_reg.dest),
    .station_addr_i(station_addr_i),
    .filter_hit_i(filter_hit_i),
    .control_i(c),
    .accept_o(addr_ok)
  );

  function automatic logic csum_fail(input logic [15:0] ctl, input logic ip, input logic ipb,
                                     input logic tcp, input logic tcpb,
                                     input logic udp, input logic udpb);
    csum_fail = (ctl[rx_accept_pkg::UDP_CHECKSUM_CHECK_EN_BIT] && udp && udpb)
              || (ctl[rx_accept_pkg::TCP_CHECKSUM_CHECK_EN_BIT] && tcp && tcpb)
              || (ctl[rx_accept_pkg::IP_HEADER_CHECKSUM_CHECK_EN_BIT] && ip && ipb);
  endfunction

  // Write and read both decode the control register address
  function automatic logic ctrl_sel(input logic [7:0] a);
    ctrl_sel = (a == rx_accept_pkg::RECEIVE_CONTROL_ONE_OFFSET);
  endfunction

  always_comb begin
    st_next = st_reg;
    st_next.store = 1'b0;
    st_next.drop = 1'b0;
    pause_load = 1'b0;
    // Byte enables let the host write either half; all bits read back as written
    if (reg_wr_i && ctrl_sel(reg_addr_i)) begin
      if (reg_be_i[0]) begin
        st_next.ctrl[7:0] = reg_wdata_i[7:0];
      end
      if (reg_be_i[1]) begin
        st_next.ctrl[15:8] = reg_wdata_i[15:8];
      end
    end
    st_next.rdata = ctrl_sel(reg_addr_i) ? st_next.ctrl : 16'h0000;
    st_next.flush = st_next.ctrl[rx_accept_pkg::RX_QUEUE_FLUSH_BIT];
    case (st_reg.state)
      rx_accept_pkg::RX_STOPPED: begin
        if (c[rx_accept_pkg::RX_RUN_ENABLE_BIT]) begin
          st_next.state = rx_accept_pkg::RX_RUNNING;
        end
      end
      rx_accept_pkg::RX_RUNNING: begin
        if (!c[rx_accept_pkg::RX_RUN_ENABLE_BIT]) begin
          st_next.state = rx_accept_pkg::RX_STOPPED;
        end else if (frame_start_i) begin
          st_next.state = rx_accept_pkg::RX_IN_FRAME;
          st_next.dest = dest_addr_i;
        end
      end
      rx_accept_pkg::RX_IN_FRAME: begin
        // Run enable is only looked at on frame end so the current frame completes
        if (frame_end_i) begin
          st_next.state = c[rx_accept_pkg::RX_RUN_ENABLE_BIT] ? rx_accept_pkg::RX_RUNNING
                                                              : rx_accept_pkg::RX_STOPPED;
          // A flush in progress swallows the frame rather than corrupt the queue
          if (!addr_ok || st_reg.flush
              || (crc_error_i && !c[rx_accept_pkg::CRC_ERROR_FRAME_ACCEPT_BIT])
              || csum_fail(c, is_ip_i, ip_csum_bad_i, is_tcp_i, tcp_csum_bad_i,
                           is_udp_i, udp_csum_bad_i)) begin
            st_next.drop = 1'b1;
          end else begin
            st_next.store = 1'b1;
          end
          if (is_pause_i && !crc_error_i && full_duplex_i
              && c[rx_accept_pkg::PAUSE_HONOUR_EN_BIT]) begin
            st_next.quanta = pause_quanta_i;
            st_next.sub = 7'h00;
            pause_load = 1'b1;
          end
        end
      end
      default: st_next.state = rx_accept_pkg::RX_STOPPED;
    endcase
    st_next.running = (st_next.state != rx_accept_pkg::RX_STOPPED);
    // Pause timer: a quantum is PAUSE_QUANTUM_CYCLES clocks; a new pause frame restarts it
    if (st_reg.quanta != 16'h0000 && !pause_load) begin
      if (st_reg.sub == 7'(rx_accept_pkg::PAUSE_QUANTUM_CYCLES - 1)) begin
        st_next.sub = 7'h00;
        st_next.quanta = st_reg.quanta - 16'h0001;
      end else begin
        st_next.sub = st_reg.sub + 7'h01;
      end
    end
    // Pause only means something in full duplex; the pause timer is cleared otherwise
    if (!full_duplex_i) begin
      st_next.quanta = 16'h0000;
    end
    st_next.hold = (st_next.quanta != 16'h0000);
  end

  // The address match sees the destination captured at frame start
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
      st_reg.ctrl <= rx_accept_pkg::RECEIVE_CONTROL_ONE_RESET;
      st_reg.state <= rx_accept_pkg::RX_STOPPED;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_o = st_reg.rdata;
  assign frame_store_o = st_reg.store;
  assign frame_drop_o = st_reg.drop;
  assign queue_flush_o = st_reg.flush;
  assign rx_running_o = st_reg.running;
  assign tx_pause_hold_o = st_reg.hold;
endmodule : rx_frame_accept_control

`default_nettype wire

// File: verification/net_frame_src.sv
// Frame source model standing in for the MAC receive path.
// Assumes the bench calls send from one process only.
`default_nettype none
module net_frame_src (
  // Clock
  input wire logic clk_i,
  // Frame side
  output logic start_o,
  output logic end_o,
  output logic [47:0] dest_o,
  output logic [7:0] flags_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    start_o = 1'b0;
    end_o = 1'b0;
    dest_o = 48'h0;
    flags_o = 8'h00;
  end
  task automatic send(input logic [47:0] d, input logic [7:0] f);
    @(posedge clk_i);
    start_o <= 1'b1;
    dest_o <= d;
    @(posedge clk_i);
    start_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    end_o <= 1'b1;
    flags_o <= f;
    @(posedge clk_i);
    end_o <= 1'b0;
    // Released lines go inverse so a stale value never looks valid
    dest_o <= ~d;
    flags_o <= ~f;
  endtask
endmodule // net_frame_src
`default_nettype wire

// File: verification/rx_accept_asserts.sv
// Port assertions for the receive accept control block, bound to its top.
// Assumes a shadow of the control word built from host writes.
`default_nettype none
module rx_accept_asserts (
  // Clock, reset and host port
  input wire logic mclk_i, rst_n_i, reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [1:0] reg_be_i,
  input wire logic [15:0] reg_wdata_i, reg_rdata_o, pause_quanta_i,
  // Frame inputs
  input wire logic full_duplex_i, frame_start_i, frame_end_i, crc_error_i, is_pause_i,
  input wire logic is_ip_i, ip_csum_bad_i, is_tcp_i, tcp_csum_bad_i, is_udp_i, udp_csum_bad_i,
  // Decisions
  input wire logic frame_store_o, frame_drop_o, queue_flush_o, rx_running_o, tx_pause_hold_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] sh;
  logic wr_ctrl, clean, csum_bad;
  assign wr_ctrl = reg_wr_i && reg_addr_i == rx_accept_pkg::RECEIVE_CONTROL_ONE_OFFSET;
  assign clean = !crc_error_i && !ip_csum_bad_i && !tcp_csum_bad_i && !udp_csum_bad_i;
  assign csum_bad = (sh[12] && is_ip_i && ip_csum_bad_i) || (sh[13] && is_tcp_i && tcp_csum_bad_i)
      || (sh[14] && is_udp_i && udp_csum_bad_i);
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sh <= rx_accept_pkg::RECEIVE_CONTROL_ONE_RESET;
    end else if (wr_ctrl) begin
      sh <= {reg_be_i[1] ? reg_wdata_i[15:8] : sh[15:8], reg_be_i[0] ? reg_wdata_i[7:0] : sh[7:0]};
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_reg_readback: assert property (
    wr_ctrl && reg_be_i == 2'h3 |=> reg_rdata_o == $past(reg_wdata_i)) else $error("readback wrong");
  a_flush_level: assert property (
    wr_ctrl && reg_be_i[1] |-> ##2 queue_flush_o == $past(reg_wdata_i[15], 2)) else $error("flush");
  a_run_on_enable: assert property (
    wr_ctrl && reg_be_i[0] && reg_wdata_i[0] |-> ##2 rx_running_o) else $error("not running");
  a_crc_discard: assert property (
    frame_end_i && crc_error_i && !sh[9] |=> !frame_store_o) else $error("crc frame stored");
  a_csum_discard: assert property (
    frame_end_i && csum_bad |=> frame_drop_o && !frame_store_o) else $error("bad sum stored");
  a_promisc_take: assert property (
    frame_end_i && rx_running_o && clean && sh[4] && !sh[1] && !sh[15] |=> frame_store_o)
    else $error("frame not taken");
  a_stopped_ignore: assert property (
    !rx_running_o && frame_start_i |-> ##1 (!frame_store_o && !frame_drop_o) [*5])
    else $error("pulse while stopped");
  a_pause_start: assert property (
    frame_end_i && rx_running_o && is_pause_i && !crc_error_i && full_duplex_i && sh[10]
    && pause_quanta_i != 16'h0000 |=> tx_pause_hold_o) else $error("pause hold missing");
  c_store: cover property (frame_store_o);
  c_drop: cover property (frame_drop_o);
  c_pause: cover property (tx_pause_hold_o);
endmodule // rx_accept_asserts
bind rx_frame_accept_control rx_accept_asserts u_chk (.mclk_i, .rst_n_i, .reg_wr_i, .reg_addr_i,
  .reg_be_i, .reg_wdata_i, .reg_rdata_o, .pause_quanta_i, .full_duplex_i, .frame_start_i,
  .frame_end_i, .crc_error_i, .is_pause_i, .is_ip_i, .ip_csum_bad_i, .is_tcp_i, .tcp_csum_bad_i,
  .is_udp_i, .udp_csum_bad_i, .frame_store_o, .frame_drop_o, .queue_flush_o, .rx_running_o,
  .tx_pause_hold_o);
`default_nettype wire

// File: verification/rx_frame_accept_control_tb.sv
// Self-checking bench for the receive accept control block.
// Assumes the package, design, model and checker are compiled first.
`default_nettype none
module rx_frame_accept_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, wr = 1'b0, hit = 1'b0;
  logic fdx = 1'b1; // Full duplex throughout, so pause honour is legal
  logic [1:0] be = 2'h3;
  logic [7:0] addr = 8'h00, fl;
  logic [15:0] wd = 16'h0000, rd;
  logic [47:0] me = 48'h02AB_CD00_0001, dst;
  logic sf, ef, st, dr, fq, run, ph;
  int mismatches = 0, n_compared = 0;
  always #5 mclk_i = ~mclk_i;
  net_frame_src src (.clk_i(mclk_i), .start_o(sf), .end_o(ef), .dest_o(dst), .flags_o(fl));
  rx_frame_accept_control dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_be_i(be), .reg_wdata_i(wd), .reg_rdata_o(rd), .station_addr_i(me),
    .filter_hit_i(hit), .full_duplex_i(fdx), .frame_start_i(sf), .frame_end_i(ef),
    .dest_addr_i(dst), .crc_error_i(fl[7]), .is_ip_i(fl[6]), .ip_csum_bad_i(fl[5]),
    .is_tcp_i(fl[4]), .tcp_csum_bad_i(fl[3]), .is_udp_i(fl[2]), .udp_csum_bad_i(fl[1]),
    .is_pause_i(fl[0]), .pause_quanta_i(16'h0002), .frame_store_o(st), .frame_drop_o(dr),
    .queue_flush_o(fq), .rx_running_o(run), .tx_pause_hold_o(ph));
  task automatic chk(input logic [15:0] s, input logic [15:0] e, input string n);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrr(input logic [1:0] b, input logic [15:0] d);
    @(posedge mclk_i);
    addr <= rx_accept_pkg::RECEIVE_CONTROL_ONE_OFFSET;
    be <= b;
    wd <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rdr(input logic [7:0] a, input logic [15:0] e, input string n);
    @(posedge mclk_i);
    addr <= a;
    @(posedge mclk_i);
    #1 chk(rd, e, n);
  endtask
  task automatic fr(input logic [47:0] d, input logic [7:0] f, input logic se, input logic de);
    src.send(d, f);
    #1 chk({14'h0, st, dr}, {14'h0, se, de}, "store_drop");
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk_i);
    mismatches++;
    results();
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rdr(8'h74, 16'h0800, "ctrl_reset");
    rdr(8'h76, 16'h0000, "unmapped");
    wrr(2'h3, 16'h7A0E);
    rdr(8'h74, 16'h7A0E, "ctrl_rw");
    wrr(2'h1, 16'hFFFF);
    rdr(8'h74, 16'h7AFF, "lane_low");
    wrr(2'h3, 16'h0011);
    fr(48'h0, 8'h00, 1'b1, 1'b0);
    fr(48'h0, 8'h80, 1'b0, 1'b1);
    wrr(2'h3, 16'h0211);
    fr(48'h0, 8'h80, 1'b1, 1'b0);
    for (int i = 0; i < 3; i++) begin
      wrr(2'h3, 16'h0011 | (16'h1000 << i));
      fr(48'h0, 8'h60 >> (2 * i), 1'b0, 1'b1);
    end
    // With the checks off a bad header sum must still land
    wrr(2'h3, 16'h0011);
    fr(48'h0, 8'h60, 1'b1, 1'b0);
    wrr(2'h3, 16'h0081);
    fr(rx_accept_pkg::BROADCAST_ADDR, 8'h00, 1'b1, 1'b0);
    fr(48'h0200_0000_0009, 8'h00, 1'b0, 1'b1);
    wrr(2'h3, 16'h0083);
    fr(rx_accept_pkg::BROADCAST_ADDR, 8'h00, 1'b0, 1'b1);
    wrr(2'h3, 16'h0041);
    fr(48'h0100_0000_0003, 8'h00, 1'b1, 1'b0);
    wrr(2'h3, 16'h0021);
    fr(me, 8'h00, 1'b1, 1'b0);
    @(posedge mclk_i);
    hit <= 1'b1;
    wrr(2'h3, 16'h0801);
    fr(48'h0200_0000_0005, 8'h00, 1'b1, 1'b0);
    wrr(2'h3, 16'h0101);
    fr(48'h0100_0000_0007, 8'h00, 1'b1, 1'b0);
    @(posedge mclk_i);
    hit <= 1'b0;
    wrr(2'h3, 16'h0411);
    fr(48'h0, 8'h01, 1'b1, 1'b0);
    @(posedge mclk_i);
    #1 chk({15'h0, ph}, 16'h0001, "pause_hold");
    // Two quanta were sent: the hold stands for exactly two quantum periods
    repeat (2 * rx_accept_pkg::PAUSE_QUANTUM_CYCLES - 2) @(posedge mclk_i);
    #1 chk({15'h0, ph}, 16'h0001, "pause_last");
    @(posedge mclk_i);
    #1 chk({15'h0, ph}, 16'h0000, "pause_end");
    // Enable cleared mid-frame: the frame still lands, then receive stops
    fork
      fr(48'h0, 8'h00, 1'b1, 1'b0);
      begin
        @(posedge mclk_i);
        wrr(2'h3, 16'h0010); // Enable off before flush
      end
    join
    chk({15'h0, run}, 16'h0000, "stop_after_frame");
    fr(48'h0, 8'h00, 1'b0, 1'b0);
    wrr(2'h3, 16'h8010);
    @(posedge mclk_i);
    #1 chk({14'h0, fq, run}, 16'h0002, "flush_on");
    wrr(2'h3, 16'h0010); // Flush cleared, run enable still off
    @(posedge mclk_i);
    #1 chk({15'h0, fq}, 16'h0000, "flush_off");
    // Reset in mid-run while receiving is enabled
    wrr(2'h3, 16'h0011);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rdr(8'h74, 16'h0800, "ctrl_rereset");
    chk({14'h0, run, fq}, 16'h0000, "rereset_idle");
    results();
  end
endmodule // rx_frame_accept_control_tb
`default_nettype wire
